// [output_compare_control.sv]
// top: AXI4-Lite register slave for one output compare channel
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module output_compare_control
  import compare_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [31:0]  second_general_timer,
  input  wire logic [31:0]  third_general_timer,
  input  wire logic         idle_mode,
  input  wire logic         fault_pin,
  output logic              compare_output_pin
);

  // ===========================================================
  // state
  logic [31:0] control_q;
  logic [31:0] primary_q;
  logic [31:0] secondary_q;
  logic [7:0]  awaddr_q;
  logic        aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_held_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        idle_meta_q;
  logic        idle_q;
  logic        fault_meta_q;
  logic        fault_q;
  logic        fault_status;

  // ===========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction

  // plain write, or clear/set/invert of the ones written at an alias
  function automatic logic [31:0] alias_apply(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb,
                                              input logic [3:0]  sub);
    logic [31:0] m;
    m = merge(32'h0000_0000, data, strb);
    if (sub == ALIAS_CLR)      return old & ~m;
    else if (sub == ALIAS_SET) return old | m;
    else if (sub == ALIAS_INV) return old ^ m;
    else                       return merge(old, data, strb);
  endfunction

  // ===========================================================
  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_meta_q  <= 1'b0;
      idle_q       <= 1'b0;
      fault_meta_q <= 1'b0;
      fault_q      <= 1'b0;
    end else begin
      idle_meta_q  <= idle_mode;
      idle_q       <= idle_meta_q;
      fault_meta_q <= fault_pin;
      fault_q      <= fault_meta_q;
    end
  end

  // ===========================================================
  // write path: address and data taken in either order
  wire        aw_take  = s_axi_awvalid && !aw_held_q && !bvalid_q;
  wire        w_take   = s_axi_wvalid && !w_held_q && !bvalid_q;
  wire [7:0]  wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data  = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0]  wr_strb  = w_held_q ? wstrb_q : s_axi_wstrb;
  wire        wr_fire  = (aw_held_q || aw_take) && (w_held_q || w_take);
  wire [7:0]  wr_base  = {wr_addr[7:4], 4'h0};
  wire [3:0]  wr_sub   = wr_addr[3:0];
  wire        wr_ctrl  = wr_base == CONTROL_OFF;
  wire        wr_prim  = wr_base == PRIMARY_OFF;
  wire        wr_sec   = wr_base == SECONDARY_OFF;
  wire        wr_ok    = wr_sub[1:0] == 2'b00 && (wr_ctrl || wr_prim || wr_sec);

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  wire [31:0] ctrl_next = alias_apply(control_q, wr_data, wr_strb, wr_sub)
                          & CONTROL_WMASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_q <= 1'b1;
          awaddr_q  <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          wdata_q  <= s_axi_wdata;
          wstrb_q  <= s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
      end
    end
  end

  // ===========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q   <= CONTROL_RESET;
      primary_q   <= VALUE_RESET;
      secondary_q <= VALUE_RESET;
    end else if (wr_fire && wr_ok) begin
      if (wr_ctrl) control_q <= ctrl_next;
      if (wr_prim)
        primary_q <= alias_apply(primary_q, wr_data, wr_strb, wr_sub);
      if (wr_sec)
        secondary_q <= alias_apply(secondary_q, wr_data, wr_strb, wr_sub);
    end
  end

  // ===========================================================
  // channel control
  control_t    ctrl;
  assign ctrl = '{enable:       control_q[ENABLE_BIT],
                  idle_stop:    control_q[IDLE_STOP_BIT],
                  wide_compare: control_q[WIDE_BIT],
                  timer_select: control_q[TSEL_BIT],
                  compare_mode: compare_mode_t'(control_q[2:0])};

  wire run = ctrl.enable && !(ctrl.idle_stop && idle_q);
  wire [31:0] timer_value = ctrl.timer_select ? third_general_timer
                                              : second_general_timer;

  compare_engine engine (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .ctrl                    (ctrl),
    .run                     (run),
    .timer_value             (timer_value),
    .primary_compare_value   (primary_q),
    .secondary_compare_value (secondary_q),
    .fault_sync              (fault_q),
    .compare_output_pin      (compare_output_pin),
    .fault_status            (fault_status)
  );

  // ===========================================================
  // read path; any alias of a register reads the register itself
  wire [7:0]  rd_base = {s_axi_araddr[7:4], 4'h0};
  wire [31:0] ctrl_view = (control_q & CONTROL_WMASK)
                          | ({31'h0, fault_status} << FAULT_BIT);
  wire        rd_ok = s_axi_araddr[1:0] == 2'b00 &&
                      (rd_base == CONTROL_OFF || rd_base == PRIMARY_OFF ||
                       rd_base == SECONDARY_OFF);
  wire [31:0] rd_val =
    rd_base == CONTROL_OFF   ? ctrl_view :
    rd_base == PRIMARY_OFF   ? primary_q :
    rd_base == SECONDARY_OFF ? secondary_q : 32'h0000_0000;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_ok ? rd_val : 32'h0000_0000;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ===========================================================
  // checks
  // last cycle's write data, for the alias check one edge later
  logic [31:0] wr_data_past_q;
  always_ff @(posedge aclk) wr_data_past_q <= wr_data;

  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (control_q & ~CONTROL_WMASK) == 32'h0000_0000)
    else $error("reserved control bit became set");
  a_alias_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_ctrl && wr_sub == ALIAS_SET && wr_strb == 4'hF
    |=> (control_q & (wr_data_past_q & CONTROL_WMASK))
        == (wr_data_past_q & CONTROL_WMASK))
    else $error("set alias did not set bits");

endmodule : output_compare_control
`default_nettype wire

// [compare_pkg.sv]
// shared constants and carrier types for the output compare channel
package compare_pkg;

  // ===========================================================
  // register map (byte offsets)
  localparam logic [7:0] CONTROL_OFF   = 8'h00;
  localparam logic [7:0] PRIMARY_OFF   = 8'h10;
  localparam logic [7:0] SECONDARY_OFF = 8'h20;
  localparam logic [7:0] SECOND_GENERAL_TIMER_OFF    = 8'h30;
  localparam logic [7:0] THIRD_GENERAL_TIMER_OFF    = 8'h40;
  localparam logic [7:0] STATUS_OFF    = 8'h50;
  localparam logic [3:0] ALIAS_CLR     = 4'h4;
  localparam logic [3:0] ALIAS_SET     = 4'h8;
  localparam logic [3:0] ALIAS_INV     = 4'hC;

  // ===========================================================
  // control field positions and reset values
  localparam int ENABLE_BIT    = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int WIDE_BIT      = 5;
  localparam int FAULT_BIT     = 4;
  localparam int TSEL_BIT      = 3;
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_A02F;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] VALUE_RESET   = 32'h0000_0000;
  localparam logic [31:0] LOW16_MASK    = 32'h0000_FFFF;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_SET_HIGH = 3'b001,
    MODE_SET_LOW  = 3'b010,
    MODE_TOGGLE   = 3'b011,
    MODE_ONE_PULSE = 3'b100,
    MODE_PULSES   = 3'b101,
    MODE_PWM      = 3'b110,
    MODE_PWM_FLT  = 3'b111
  } compare_mode_t;

  typedef struct packed {
    logic          enable;
    logic          idle_stop;
    logic          wide_compare;
    logic          timer_select;
    compare_mode_t compare_mode;
  } control_t;

endpackage : compare_pkg

// [compare_engine.sv]
// pin engine: compares the timer against both values and shapes the pin
`timescale 1ns/100ps
`default_nettype none
module compare_engine
  import compare_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire compare_pkg::control_t ctrl,
  input  wire logic            run,
  input  wire logic [31:0]     timer_value,
  input  wire logic [31:0]     primary_compare_value,
  input  wire logic [31:0]     secondary_compare_value,
  input  wire logic            fault_sync,
  output logic                 compare_output_pin,
  output logic                 fault_status
);

  logic        pin_q;
  logic        pin_d;
  logic        done_q;
  logic        done_d;
  logic        fault_q;
  logic        fault_d;
  logic [2:0]  mode_q;
  wire  [31:0] mask;
  wire         hit_primary;
  wire         hit_secondary;
  wire         mode_change;
  wire         pwm_mode;

  // narrow mode only looks at low halves of timer and values
  assign mask = ctrl.wide_compare ? 32'hFFFF_FFFF : LOW16_MASK;
  assign hit_primary = run &&
    ((timer_value & mask) == (primary_compare_value & mask));
  assign hit_secondary = run &&
    ((timer_value & mask) == (secondary_compare_value & mask));
  assign mode_change = (mode_q != ctrl.compare_mode) || !ctrl.enable;
  assign pwm_mode = ctrl.compare_mode[2] && ctrl.compare_mode[1];

  // ===========================================================
  // pin behaviour
  always_comb begin
    pin_d  = pin_q;
    done_d = done_q;
    if (!ctrl.enable) begin
      pin_d  = 1'b0;
      done_d = 1'b0;
    end else if (mode_change) begin
      done_d = 1'b0;
      case (ctrl.compare_mode)
        MODE_SET_LOW:   pin_d = 1'b1;
        MODE_SET_HIGH,
        MODE_ONE_PULSE,
        MODE_PULSES:    pin_d = 1'b0;
        MODE_PWM,
        MODE_PWM_FLT:   pin_d = 1'b0;
        default:        pin_d = pin_q;
      endcase
    end else begin
      case (ctrl.compare_mode)
        MODE_SET_HIGH: if (hit_primary) pin_d = 1'b1;
        MODE_SET_LOW:  if (hit_primary) pin_d = 1'b0;
        MODE_TOGGLE:   if (hit_primary) pin_d = !pin_q;
        MODE_ONE_PULSE: begin
          if (hit_primary && !done_q) pin_d = 1'b1;
          if (hit_secondary && pin_q) begin
            pin_d  = 1'b0;
            done_d = 1'b1;
          end
        end
        MODE_PULSES: begin
          if (hit_primary) pin_d = 1'b1;
          if (hit_secondary) pin_d = 1'b0;
        end
        MODE_PWM,
        MODE_PWM_FLT: begin
          if (hit_primary) pin_d = 1'b1;
          if (hit_secondary) pin_d = 1'b0;
          if (ctrl.compare_mode == MODE_PWM_FLT && (fault_sync || fault_q))
            pin_d = 1'b0;
        end
        default: pin_d = pin_q;
      endcase
    end
  end

  // fault latches in fault mode and is cleared only by hardware, on leaving it or when the channel is disabled
  always_comb begin
    fault_d = fault_q;
    if (ctrl.compare_mode != MODE_PWM_FLT || !ctrl.enable)
      fault_d = 1'b0;
    else if (fault_sync)
      fault_d = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q   <= 1'b0;
      done_q  <= 1'b0;
      fault_q <= 1'b0;
      mode_q  <= MODE_OFF;
    end else begin
      pin_q   <= pin_d;
      done_q  <= done_d;
      fault_q <= fault_d;
      mode_q  <= ctrl.enable ? ctrl.compare_mode : MODE_OFF;
    end
  end

  assign compare_output_pin = pin_q;
  assign fault_status = fault_q && ctrl.compare_mode == MODE_PWM_FLT;

  // ===========================================================
  // checks
  a_fault_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_q && $stable(ctrl) |=> fault_q)
    else $error("fault flag dropped while mode held");
  a_fault_mode_only: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.compare_mode != MODE_PWM_FLT
    |-> !fault_status ##1 !fault_q)
    else $error("fault flag visible outside fault mode");
  a_set_high: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && ctrl.compare_mode == MODE_SET_HIGH && !mode_change
    && hit_primary |=> compare_output_pin)
    else $error("set-high compare did not raise pin");
  a_set_low: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && ctrl.compare_mode == MODE_SET_LOW && !mode_change
    && hit_primary |=> !compare_output_pin)
    else $error("set-low compare did not drop pin");
  a_toggle_flip: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && ctrl.compare_mode == MODE_TOGGLE && !mode_change
    && hit_primary |=> compare_output_pin != $past(compare_output_pin))
    else $error("toggle compare did not flip pin");
  a_disabled_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl.enable |=> !compare_output_pin)
    else $error("pin not low while disabled");
  a_off_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && ctrl.compare_mode == MODE_OFF
    && $past(ctrl.compare_mode) == MODE_OFF && $past(ctrl.enable)
    |-> $stable(compare_output_pin))
    else $error("pin moved in off mode");
  a_fault_forces: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && ctrl.compare_mode == MODE_PWM_FLT && !mode_change
    && fault_sync |=> !compare_output_pin && fault_q)
    else $error("fault did not force pin low");
  a_pwm_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && ctrl.compare_mode == MODE_PWM && !mode_change
    && hit_primary && !hit_secondary |=> compare_output_pin)
    else $error("pwm did not rise at primary match");
  a_pwm_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && pwm_mode && !mode_change && hit_secondary
    |=> !compare_output_pin)
    else $error("pwm did not fall at secondary match");
  a_init_low: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.enable && mode_change && ctrl.compare_mode[2] |=>
    !compare_output_pin)
    else $error("pulse mode did not start low");

endmodule : compare_engine
`default_nettype wire

// [pin_load.sv]
// load model on the compare output pin: counts rising edges it sees
`timescale 1ns/100ps
`default_nettype none
module pin_load (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        level,
  output logic [31:0]      rises_q
);
  logic level_q;

  // ===========================================================
  // edge counter
  // a passive load never drives back, so counting edges is all it needs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'h0;
      rises_q <= 32'h0;
    end else begin
      level_q <= level;
      if (level && !level_q) begin
        rises_q <= rises_q + 32'h1;
      end
    end
  end
endmodule // pin_load
`default_nettype wire

// [tb.sv]
// self-checking bench for the output compare channel
`timescale 1ns/100ps
`default_nettype none
module tb;
  import compare_pkg::*;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] rd;
    logic [1:0]  rs;
  } reg_row_t;
  typedef struct packed {
    logic [31:0] ctl;
    logic        on3;
    logic        idl;
    logic [31:0] va;
    logic [31:0] vb;
    logic [31:0] vc;
    logic [3:0]  ex;
  } pin_row_t;
  localparam logic [31:0] P = 32'h0001_0005;
  localparam logic [31:0] S = 32'h0001_0009;
  localparam logic [31:0] QUIET = 32'h0000_7777;
  localparam logic [1:0] OK = RESP_OKAY;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h0;
  logic        awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic [7:0]  araddr = 8'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic [31:0] t2 = QUIET;
  logic [31:0] t3 = QUIET;
  logic        idle = 1'h0;
  logic        fault = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pin;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rises;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  reg_row_t regs [10] = '{
    '{8'h00, 32'hFFFF_FFFF, 8'h00, 32'h0000_A02F, OK},
    '{8'h04, 32'h0000_A000, 8'h00, 32'h0000_002F, OK},
    '{8'h08, 32'h0000_8000, 8'h00, 32'h0000_802F, OK},
    '{8'h0C, 32'h0000_000F, 8'h00, 32'h0000_8020, OK},
    '{8'h10, 32'h1234_5678, 8'h10, 32'h1234_5678, OK},
    '{8'h14, 32'h0000_0078, 8'h10, 32'h1234_5600, OK},
    '{8'h20, 32'h0000_FFFF, 8'h20, 32'h0000_FFFF, OK},
    '{8'h2C, 32'h0000_00FF, 8'h20, 32'h0000_FF00, OK},
    '{8'h30, 32'hFFFF_FFFF, 8'h30, 32'h0, RESP_SLVERR},
    '{8'h00, 32'h0, 8'h00, 32'h0, OK}};
  pin_row_t pins [16] = '{
    '{32'h8001, 1'h0, 1'h0, P, P, P, 4'h7},
    '{32'h8002, 1'h0, 1'h0, P, P, P, 4'h8},
    '{32'h8003, 1'h0, 1'h0, P, P, P, 4'h5},
    '{32'h8004, 1'h0, 1'h0, P, S, P, 4'h4},
    '{32'h8005, 1'h0, 1'h0, P, S, P, 4'h5},
    '{32'h8006, 1'h0, 1'h0, P, S, P, 4'h5},
    '{32'h8007, 1'h0, 1'h0, P, S, P, 4'h5},
    '{32'h0002, 1'h0, 1'h0, P, P, P, 4'h0},
    '{32'h8000, 1'h0, 1'h0, P, P, P, 4'h0},
    '{32'h8001, 1'h0, 1'h0, 32'hABCD_0005, P, P, 4'h7},
    '{32'h8021, 1'h0, 1'h0, 32'h5, 32'h5, P, 4'h1},
    '{32'h8009, 1'h0, 1'h0, P, P, P, 4'h0},
    '{32'h8009, 1'h1, 1'h0, P, P, P, 4'h7},
    '{32'h8001, 1'h1, 1'h0, P, P, P, 4'h0},
    '{32'hA001, 1'h0, 1'h1, P, P, P, 4'h0},
    '{32'h8001, 1'h0, 1'h1, P, P, P, 4'h7}};

  output_compare_control output_compare_control_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .second_general_timer(t2), .third_general_timer(t3),
    .idle_mode(idle), .fault_pin(fault), .compare_output_pin(pin));
  pin_load pin_load_i (.aclk(aclk), .aresetn(aresetn), .level(pin),
    .rises_q(rises));

  // ===========================================================
  // clock, watchdog and report
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t %s got %b want %b", $time, m, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t %s got %b want %b", $time, m, g, e);
    end
  endtask

  // ===========================================================
  // bus master: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ga;
    logic gw;
    ga = 1'h0;
    gw = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (!ga && awready === 1'h1) begin
        ga = 1'h1;
        awvalid <= 1'h0;
      end
      if (!gw && wready === 1'h1) begin
        gw = 1'h1;
        wvalid <= 1'h0;
      end
    end while (!(ga && gw));
    while (bvalid !== 1'h1) @(posedge aclk);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  // one match on the chosen timer, then quiet values until the pin settles
  task automatic ev(input logic on3, input logic [31:0] v);
    @(posedge aclk);
    if (on3) t3 <= v;
    else t2 <= v;
    @(posedge aclk);
    t2 <= QUIET;
    t3 <= QUIET;
    repeat (3) @(posedge aclk);
  endtask

  // ===========================================================
  // main sequence
  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    logic [31:0] base;
    logic [31:0] nr;
    logic        prev;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (regs[i]) begin
      wr(regs[i].wa, regs[i].wd, r);
      chk_resp(r, regs[i].rs, "bresp");
      rd(regs[i].ra, d, r);
      chk_resp(r, regs[i].rs, "rresp");
      chk_word(d, regs[i].rd, "register");
    end
    wr(PRIMARY_OFF, P, r);
    wr(SECONDARY_OFF, S, r);
    foreach (pins[i]) begin
      wr(CONTROL_OFF, 32'h0, r);
      // leave a quiet cycle after the enable drops
      @(posedge aclk);
      idle <= pins[i].idl;
      base = rises;
      wr(CONTROL_OFF, pins[i].ctl, r);
      chk_resp(r, OK, "ctl write");
      repeat (3) @(posedge aclk);
      chk_bit(pin, pins[i].ex[3], "initial level");
      ev(pins[i].on3, pins[i].va);
      chk_bit(pin, pins[i].ex[2], "first event");
      ev(pins[i].on3, pins[i].vb);
      chk_bit(pin, pins[i].ex[1], "second event");
      ev(pins[i].on3, pins[i].vc);
      chk_bit(pin, pins[i].ex[0], "third event");
      nr = 32'h0;
      prev = 1'h0;
      for (int k = 3; k >= 0; k--) begin
        if (pins[i].ex[k] && !prev) nr = nr + 32'h1;
        prev = pins[i].ex[k];
      end
      chk_word(rises - base, nr, "pulse count");
      idle <= 1'h0;
    end
    // a latched fault holds the pin low and outlives the fault pin
    fault <= 1'h1;
    wr(CONTROL_OFF, 32'h0000_8007, r);
    repeat (4) @(posedge aclk);
    rd(CONTROL_OFF, d, r);
    chk_word(d, 32'h0000_8017, "fault set");
    ev(1'h0, P);
    chk_bit(pin, 1'h0, "fault forces low");
    fault <= 1'h0;
    repeat (4) @(posedge aclk);
    // software tries to clear the flag through the clear alias
    wr(8'h04, 32'h0000_0010, r);
    wr(CONTROL_OFF, 32'h0000_8007, r);
    rd(CONTROL_OFF, d, r);
    chk_word(d, 32'h0000_8017, "fault kept");
    // leaving 111 clears the flag; 110 ignores the fault pin
    fault <= 1'h1;
    wr(CONTROL_OFF, 32'h0000_8006, r);
    repeat (4) @(posedge aclk);
    rd(CONTROL_OFF, d, r);
    chk_word(d, 32'h0000_8006, "fault ignored");
    ev(1'h0, P);
    chk_bit(pin, 1'h1, "pwm ignores fault");
    fault <= 1'h0;
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CONTROL_OFF, d, r);
    chk_word(d, CONTROL_RESET, "control reset");
    rd(PRIMARY_OFF, d, r);
    chk_word(d, VALUE_RESET, "primary reset");
    chk_bit(pin, 1'h0, "pin reset");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
